/* File: design/vim_monitor.sv */
/*
 * Velocity instability monitor: limit and threshold registers, excess
 * duration counter, sticky instability fault and velocity excitation gate.
 * Assumes mode, injection point and feedback are synchronous to ref_clk_i.
 */
`timescale 1ns/10ps

// Functional notes
// (R1) Monitor feedback velocity only while analysis mode selects the stability test.
// (R2) Count duration while feedback velocity exceeds the velocity fault threshold.
// (R3) Raise instability fault, number 133, when duration reaches the limit.
// (R4) Duration limit in milliseconds, 1 to 60000, resets to zero.
// (R5) Threshold non-negative, at most 15000 rpm, resets to zero.
// (R6) Excitation amplitude drives injection only when injection point selects velocity.
// (R7) Duration clears when velocity drops to threshold or the test mode ends.
module vim_monitor #(
    parameter int MS_CYCLES = vim_pkg::VIM_MS_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire vim_pkg::vim_reg_req_t reg_req_i,
    output vim_pkg::vim_reg_rsp_t reg_rsp_o,
    input wire logic [7:0] analysis_mode_i,
    input wire logic [7:0] excitation_injection_point_i,
    input wire logic signed [63:0] feedback_velocity_i,
    input wire logic signed [63:0] velocity_excitation_amplitude_i,
    input wire logic fault_clear_i,
    output logic instability_fault_o,
    output logic [7:0] fault_code_o,
    output logic monitor_active_o,
    output logic signed [63:0] excitation_magnitude_o
);

    ////////////////////////////////////////////////////////////////////////
    // Range checks
    function automatic logic limit_ok(input logic [31:0] v);
        limit_ok = (v != 32'h0000_0000) && (v <= vim_pkg::VIM_LIMIT_MAX_MS);
    endfunction

    function automatic logic thresh_ok(input logic [63:0] v);
        thresh_ok = !v[63] && (v <= vim_pkg::VIM_THRESH_MAX);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register decode and packing
    function automatic logic addr_is(input vim_pkg::vim_reg_req_t r, input logic [15:0] ofs);
        addr_is = (r.addr == ofs);
    endfunction

    function automatic logic [31:0] status_pack(input logic [31:0] d, input logic [7:0] c, input logic e,
        input logic a, input logic f);
        status_pack = {d[15:0], c, 5'h00, e, a, f};
    endfunction

    // Saturates so a very long excess never wraps back below the limit
    function automatic logic [31:0] sat_inc(input logic [31:0] v);
        sat_inc = (v == 32'hffff_ffff) ? v : v + 32'h0000_0001;
    endfunction

    logic [31:0] velocity_fault_duration_limit_ff;
    logic [63:0] velocity_fault_threshold_ff;
    logic [31:0] dur_ff;
    logic fault_ff;
    logic active_ff;
    logic [7:0] code_ff;
    logic signed [63:0] mag_ff;
    vim_pkg::vim_reg_rsp_t rsp_ff;
    logic active;
    logic excess;
    logic tick;
    logic [63:0] nxt_thresh_lo;
    logic [63:0] nxt_thresh_hi;
    logic wr_limit;
    logic wr_thresh_lo;
    logic wr_thresh_hi;
    logic fault_set;
    logic [31:0] rd_word;

    ////////////////////////////////////////////////////////////////////////
    // Monitor condition
    assign active = (analysis_mode_i == vim_pkg::VIM_MODE_STABILITY); // R1
    assign excess = active && (feedback_velocity_i > $signed(velocity_fault_threshold_ff)); // R2
    assign nxt_thresh_lo = {velocity_fault_threshold_ff[63:32], reg_req_i.wdata};
    assign nxt_thresh_hi = {reg_req_i.wdata, velocity_fault_threshold_ff[31:0]};

    ////////////////////////////////////////////////////////////////////////
    // Write strobes, each gated by its range check
    assign wr_limit = reg_req_i.wr && addr_is(reg_req_i, vim_pkg::VIM_OFS_LIMIT)
        && limit_ok(reg_req_i.wdata); // R4
    assign wr_thresh_lo = reg_req_i.wr && addr_is(reg_req_i, vim_pkg::VIM_OFS_THRESH_LO)
        && thresh_ok(nxt_thresh_lo); // R5
    assign wr_thresh_hi = reg_req_i.wr && addr_is(reg_req_i, vim_pkg::VIM_OFS_THRESH_HI)
        && thresh_ok(nxt_thresh_hi); // R5

    ////////////////////////////////////////////////////////////////////////
    // Fault set condition, a zero limit keeps it off
    assign fault_set = excess && (velocity_fault_duration_limit_ff != 32'h0000_0000)
        && (dur_ff >= velocity_fault_duration_limit_ff); // R3

    vim_ms_tick #(
        .CYCLES(MS_CYCLES)
    ) u_tick (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .run_i(excess),
        .tick_o(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Limit register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            velocity_fault_duration_limit_ff <= vim_pkg::VIM_LIMIT_RST; // R4
        end else if (wr_limit) begin
            velocity_fault_duration_limit_ff <= reg_req_i.wdata; // R4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Threshold register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            velocity_fault_threshold_ff <= vim_pkg::VIM_THRESH_RST; // R5
        end else if (wr_thresh_lo) begin
            velocity_fault_threshold_ff <= nxt_thresh_lo; // R5
        end else if (wr_thresh_hi) begin
            velocity_fault_threshold_ff <= nxt_thresh_hi; // R5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Duration counter in milliseconds
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            dur_ff <= 32'h0000_0000;
        end else if (!excess) begin
            dur_ff <= 32'h0000_0000; // R7
        end else if (tick) begin
            dur_ff <= sat_inc(dur_ff); // R2
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky fault, set wins over clear
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            fault_ff <= 1'b0;
            code_ff <= 8'h00;
        end else if (fault_set) begin
            fault_ff <= 1'b1; // R3
            code_ff <= vim_pkg::VIM_FAULT_NUM; // R3
        end else if (fault_clear_i) begin
            fault_ff <= 1'b0;
            code_ff <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Active flag and excitation gate
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            active_ff <= 1'b0;
            mag_ff <= 64'sh0;
        end else begin
            active_ff <= active; // R1
            if (excitation_injection_point_i == vim_pkg::VIM_INJECT_VELOCITY) begin
                mag_ff <= velocity_excitation_amplitude_i; // R6
            end else begin
                mag_ff <= 64'sh0; // R6
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.valid <= reg_req_i.rd;
            if (reg_req_i.rd) begin
                rsp_ff.data <= rd_word;
            end else begin
                rsp_ff.data <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data select, unmapped indices read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (addr_is(reg_req_i, vim_pkg::VIM_OFS_LIMIT)) begin
            rd_word = velocity_fault_duration_limit_ff;
        end else if (addr_is(reg_req_i, vim_pkg::VIM_OFS_THRESH_LO)) begin
            rd_word = velocity_fault_threshold_ff[31:0];
        end else if (addr_is(reg_req_i, vim_pkg::VIM_OFS_THRESH_HI)) begin
            rd_word = velocity_fault_threshold_ff[63:32];
        end else if (addr_is(reg_req_i, vim_pkg::VIM_OFS_STATUS)) begin
            rd_word = status_pack(dur_ff, code_ff, excess, active_ff, fault_ff);
        end
    end

    assign reg_rsp_o = rsp_ff;
    assign instability_fault_o = fault_ff;
    assign fault_code_o = code_ff;
    assign monitor_active_o = active_ff;
    assign excitation_magnitude_o = mag_ff;

endmodule // vim_monitor

/* File: design/vim_pkg.sv */
/*
 * Constants and carrier types for the velocity instability monitor.
 * Assumes one 100 MHz clock and velocities in signed milli-rpm on 64 bits.
 */
package vim_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices
    localparam logic [15:0] VIM_OFS_LIMIT = 16'h0514;
    localparam logic [15:0] VIM_OFS_THRESH_LO = 16'h0516;
    localparam logic [15:0] VIM_OFS_THRESH_HI = 16'h0517;
    localparam logic [15:0] VIM_OFS_STATUS = 16'h0518;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and ranges
    localparam logic [31:0] VIM_LIMIT_RST = 32'h0000_0000;
    localparam logic [31:0] VIM_LIMIT_MAX_MS = 32'h0000_ea60;
    localparam logic [63:0] VIM_THRESH_RST = 64'h0000_0000_0000_0000;
    localparam logic [63:0] VIM_THRESH_MAX = 64'h0000_0000_00e4_e1c0;

    ////////////////////////////////////////////////////////////////////////
    // Codes
    localparam logic [7:0] VIM_MODE_STABILITY = 8'h05;
    localparam logic [7:0] VIM_INJECT_VELOCITY = 8'h01;
    localparam logic [7:0] VIM_FAULT_NUM = 8'h85;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int VIM_CLK_PERIOD_NS = 10;
    localparam int VIM_MS_TIME_NS = 1000000;
    localparam int VIM_MS_CYCLES = VIM_MS_TIME_NS / VIM_CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } vim_reg_req_t;

    // Register read answer
    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } vim_reg_rsp_t;

endpackage

/* File: design/vim_ms_tick.sv */
/*
 * Millisecond tick generator for the duration counter.
 * Assumes run_i restarts the period whenever it falls.
 */
`timescale 1ns/10ps
module vim_ms_tick #(
    parameter int CYCLES = 100000
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    output logic tick_o
);

    logic [31:0] cnt_ff;
    logic tick_ff;

    ////////////////////////////////////////////////////////////////////////
    // Period counter
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !run_i) begin
            cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (cnt_ff == 32'(CYCLES - 1)) begin
            cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    assign tick_o = tick_ff;

endmodule // vim_ms_tick

/* File: verif/vim_monitor_assertions.sv */
/* Port assertions for vim_monitor; assumes one clock domain and the bind at the foot. */
`timescale 1ns/10ps
module vim_chk #(parameter int MS_CYCLES = 4) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire vim_pkg::vim_reg_req_t reg_req_i,
    input wire vim_pkg::vim_reg_rsp_t reg_rsp_o,
    input wire logic [7:0] analysis_mode_i,
    input wire logic [7:0] excitation_injection_point_i,
    input wire logic signed [63:0] velocity_excitation_amplitude_i,
    input wire logic fault_clear_i,
    input wire logic instability_fault_o,
    input wire logic [7:0] fault_code_o,
    input wire logic monitor_active_o,
    input wire logic signed [63:0] excitation_magnitude_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_mode_active: assert property (1 |=> monitor_active_o == ($past(analysis_mode_i) == 8'h05)) else $error("act");
    a_excite_gate: assert property (1 |=> excitation_magnitude_o ==
        ($past(excitation_injection_point_i) == 8'h01 ? $past(velocity_excitation_amplitude_i) : 64'sh0)) else $error("mag");
    a_fault_code: assert property (fault_code_o == (instability_fault_o ? 8'h85 : 8'h00)) else $error("code");
    a_read_valid: assert property (1 |=> reg_rsp_o.valid == $past(reg_req_i.rd)) else $error("valid");
    a_fault_sticky: assert property (instability_fault_o && !fault_clear_i |=> instability_fault_o) else $error("drop");
    a_fault_clear: assert property (instability_fault_o && fault_clear_i && analysis_mode_i != 8'h05
        |=> !instability_fault_o) else $error("kept");
    a_fault_cause: assert property ($rose(instability_fault_o)
        |-> monitor_active_o && $past(monitor_active_o, MS_CYCLES)) else $error("early");
    a_reset_zero: assert property (disable iff (1'b0) !rst_n_i
        |=> !instability_fault_o && !monitor_active_o && !reg_rsp_o.valid) else $error("reset");
endmodule // vim_chk
////////////////////////////////////////////////////////////
bind vim_monitor vim_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .reg_req_i(reg_req_i),
    .reg_rsp_o(reg_rsp_o),
    .analysis_mode_i(analysis_mode_i),
    .excitation_injection_point_i(excitation_injection_point_i),
    .velocity_excitation_amplitude_i(velocity_excitation_amplitude_i),
    .fault_clear_i(fault_clear_i),
    .instability_fault_o(instability_fault_o),
    .fault_code_o(fault_code_o),
    .monitor_active_o(monitor_active_o),
    .excitation_magnitude_o(excitation_magnitude_o)
);

/* File: verif/vim_servo_model.sv */
/* Servo loop stand-in, feedback follows command in one or two cycles; assumes bench timing. */
`timescale 1ns/10ps
module vim_servo_model (
    input wire logic ref_clk_i,
    input wire logic slow_i,
    input wire logic signed [63:0] cmd_i,
    output logic signed [63:0] fb_o
);
    logic signed [63:0] lag_ff;
    always_ff @(posedge ref_clk_i) begin
        lag_ff <= cmd_i;
        fb_o <= slow_i ? lag_ff : cmd_i;
    end
endmodule // vim_servo_model

/* File: verif/test_velocity_instability_monitor.sv */
/* Bench for vim_monitor: register rows, then fault and reset cases; assumes MS_CYCLES of 4. */
`timescale 1ns/10ps
module test_velocity_instability_monitor;
    logic [79:0] rows[7] = '{80'h0514_000001f4_000001f4, 80'h0514_00000000_000001f4, 80'h0514_0000ea61_000001f4,
        80'h0514_0000ea60_0000ea60, 80'h0516_00e4e1c1_00000000, 80'h0517_00000001_00000000,
        80'h0600_00000005_00000000};
    logic ref_clk = 1'b0, rst_n = 1'b0, clr = 1'b0, slow = 1'b0, flt, act;
    logic [7:0] mode = 8'h00, inj = 8'h01, code;
    logic signed [63:0] cmd = 64'sh0, fb, amp = 64'sd777, mag;
    vim_pkg::vim_reg_req_t req = '0;
    vim_pkg::vim_reg_rsp_t rsp;
    int err_count = 0, comparisons = 0, n;
    always #5 ref_clk = ~ref_clk;
    vim_servo_model u_vim_servo_model (.ref_clk_i(ref_clk), .slow_i(slow), .cmd_i(cmd), .fb_o(fb));
    vim_monitor #(.MS_CYCLES(4)) u_vim_monitor (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .reg_req_i(req), .reg_rsp_o(rsp),
        .analysis_mode_i(mode), .excitation_injection_point_i(inj), .feedback_velocity_i(fb), .fault_clear_i(clr),
        .velocity_excitation_amplitude_i(amp), .instability_fault_o(flt), .fault_code_o(code),
        .monitor_active_o(act), .excitation_magnitude_o(mag));
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk) #1;
    endtask
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        comparisons++;
        err_count += int'(g !== e);
        if (g !== e) $display("CHECK FAILED %0t %h %h", $time, g, e);
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        tick(1);
        if (!w) chk({rsp.valid, rsp.data}, {1'b1, d});
        req = '0;
        tick(1);
    endtask
    task automatic wrap_up;
        $display("%0d comparisons, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #20000 err_count++;
        wrap_up;
    end
    initial begin
        tick(8);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            acc(1'b1, rows[i][79:64], rows[i][63:32]);
            acc(1'b0, rows[i][79:64], rows[i][31:0]);
        end
        chk(mag, 64'd777);
        inj = 8'h02;
        $display("register rows done");
        acc(1'b1, 16'h0516, 32'h3e8);
        acc(1'b1, 16'h0514, 32'h2);
        chk(mag, 64'h0);
        mode = 8'h05;
        slow = 1'b1;
        repeat (3) begin
            cmd = 64'sd2000;
            tick(6);
            cmd = 64'sd1000;
            tick(1);
        end
        chk(flt, 1'b0);
        chk(act, 1'b1);
        cmd = 64'sd2000;
        for (n = 0; flt !== 1'b1 && n < 100; n++) tick(1);
        chk(n >= 8 && n <= 14, 1'b1);
        acc(1'b0, 16'h0518, 32'h0002_8507);
        mode = 8'h00;
        tick(9);
        acc(1'b0, 16'h0518, 32'h0000_8501);
        chk(act, 1'b0);
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        tick(1);
        chk({flt, code}, 9'h0);
        clr = 1'b1;
        mode = 8'h05;
        tick(12);
        chk(flt, 1'b1);
        mode = 8'h00;
        tick(1);
        chk(flt, 1'b0);
        clr = 1'b0;
        $display("fault cases done");
        rst_n = 1'b0;
        tick(8);
        rst_n = 1'b1;
        acc(1'b0, 16'h0514, 32'h0);
        acc(1'b0, 16'h0516, 32'h0);
        chk({flt, act}, 2'b00);
        $display("reset case done");
        wrap_up;
    end
endmodule // test_velocity_instability_monitor
